//--- rtl/sccs_clock_select.sv
`timescale 1ns/1ps

module sccs_clock_select (
   input  wire logic                    pclk,          // Bus clock
   input  wire logic                    presetn,       // Async reset, active low
   input  wire sccs_pkg::sccs_apb_req_t apb_req,       // APB request
   output sccs_pkg::sccs_apb_rsp_t      apb_rsp,       // APB answer
   input  wire logic                    ext_clock_pin, // Shared external clock pin
   output logic                         system_clock,  // Selected system clock
   output logic                         ext_drive_on,  // External drive on, pin taken
   output logic                         irq            // Level interrupt
);
   import sccs_pkg::*;

   sccs_state_t            st;
   sccs_state_t            next_st;
   logic                   int_level;
   logic                   int_run;
   logic                   access;
   logic                   done;
   logic                   aligned;
   logic                   hit;
   logic [7:0]             idx;
   logic [31:0]            rd_val;
   logic                   pin_rise;
   logic [IRQ_W-1:0]       irq_clr;
   logic [IRQ_W-1:0]       irq_ev;

   // Mode decode: only 010..101 drive the pin
   function automatic logic mode_on(input logic [2:0] m);
      return (m == SCCS_XM_CMOS) || (m == SCCS_XM_CMOS_DIV2) ||
             (m == SCCS_XM_RC_DIV2) || (m == SCCS_XM_CAP_DIV2);
   endfunction

   // Internal oscillator scaler
   sccs_int_divider u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .run      (int_run),
      .div_code (st.int_div),
      .level    (int_level)
   );

   // Bus decode
   assign int_run  = st.int_en && st.int_rdy;
   assign access   = apb_req.psel && apb_req.penable;
   assign done     = access && st.rsp.pready;
   assign idx      = apb_req.paddr[9:2];
   assign aligned  = (apb_req.paddr[11:10] == 2'b00) && (apb_req.paddr[1:0] == 2'b00);
   assign hit      = aligned && (idx == EXT_CTRL_IDX || idx == INT_CTRL_IDX ||
                     idx == IRQ_STATUS_IDX || idx == IRQ_CLEAR_IDX ||
                     idx == IRQ_ENABLE_IDX);
   assign pin_rise = ext_clock_pin && !st.pin_q;

   // Read mux; unused bits stay zero
   always_comb begin
      rd_val = 32'h0;
      case (idx)
         INT_CTRL_IDX: begin
            rd_val[INT_DIV_LSB +: 2] = st.int_div;
            rd_val[INT_EN_BIT]       = st.int_en;
            rd_val[CLK_SEL_BIT]      = st.clk_sel;
            rd_val[INT_RDY_BIT]      = st.int_rdy;
         end
         EXT_CTRL_IDX: begin
            // bits 7 and 3 left zero
            rd_val[EXT_FREQ_LSB +: 3] = st.ext_freq;
            rd_val[EXT_MODE_LSB +: 3] = st.ext_mode;
         end
         IRQ_STATUS_IDX: rd_val[IRQ_W-1:0] = st.irq_stat;
         IRQ_ENABLE_IDX: rd_val[IRQ_W-1:0] = st.irq_en;
         default:        rd_val = 32'h0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      next_st = st;
      irq_clr = '0;
      irq_ev  = '0;

      // Answer one cycle into the access phase; bad address errors
      next_st.rsp.pready  = access && !st.rsp.pready;
      next_st.rsp.pslverr = access && !st.rsp.pready && !hit;
      next_st.rsp.prdata  = (access && !st.rsp.pready && !apb_req.pwrite && hit) ?
                            rd_val : 32'h0;

      // Writes land on the completing edge only
      if (done && apb_req.pwrite && hit) begin
         case (idx)
            INT_CTRL_IDX: begin
               next_st.int_div = apb_req.pwdata[INT_DIV_LSB +: 2];
               next_st.int_en  = apb_req.pwdata[INT_EN_BIT];
               next_st.clk_sel = apb_req.pwdata[CLK_SEL_BIT];
            end
            EXT_CTRL_IDX: begin
               next_st.ext_mode = apb_req.pwdata[EXT_MODE_LSB +: 3];
               next_st.ext_freq = apb_req.pwdata[EXT_FREQ_LSB +: 3];
            end
            IRQ_CLEAR_IDX:  irq_clr = apb_req.pwdata[IRQ_W-1:0];
            IRQ_ENABLE_IDX: next_st.irq_en = apb_req.pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end

      if (!st.int_en) begin
         next_st.int_rdy = 1'b0;
         next_st.rdy_cnt = '0;
      end else if (!st.int_rdy) begin
         if (st.rdy_cnt == RDY_CNT_W'(INT_STARTUP_CYC - 1)) begin
            next_st.int_rdy = 1'b1;
            irq_ev[IRQ_INT_RDY] = 1'b1;
         end else begin
            next_st.rdy_cnt = st.rdy_cnt + RDY_CNT_W'(1);
         end
      end

      // drive on only for valid modes
      next_st.ext_drive_on = mode_on(next_st.ext_mode);
      next_st.pin_q        = ext_clock_pin;
      if (!st.ext_drive_on) begin
         next_st.ext_div   = 1'b0;
         next_st.ext_level = 1'b0;
         next_st.ext_cnt   = '0;
         next_st.ext_run   = 1'b0;
      end else begin
         // pin edges clock the external path
         if (pin_rise) begin
            next_st.ext_div = ~st.ext_div;
            next_st.ext_cnt = '0;
            next_st.ext_run = 1'b1;
         end else if (st.ext_cnt == EXT_CNT_W'(EXT_LOST_CYC - 1)) begin
            // Pin silent too long: source no longer counts as running
            next_st.ext_run = 1'b0;
            irq_ev[IRQ_EXT_LOST] = st.ext_run;
         end else begin
            next_st.ext_cnt = st.ext_cnt + EXT_CNT_W'(1);
         end
         next_st.ext_level = (st.ext_mode == SCCS_XM_CMOS) ? ext_clock_pin :
                             next_st.ext_div;
      end

      // switch waits for new source to run
      // hand over only while both are low
      case (st.sw)
         SCCS_SW_INT: begin
            next_st.sys_clk = int_level;
            if (st.clk_sel && st.ext_run && !int_level) begin
               next_st.sw = SCCS_SW_XFER;
            end
         end
         SCCS_SW_XFER: begin
            // Low phase stretched until the new source is low too
            next_st.sys_clk = 1'b0;
            if (st.clk_sel) begin
               if (st.ext_run && !st.ext_level) begin
                  next_st.sw = SCCS_SW_EXT;
                  irq_ev[IRQ_SWITCH] = 1'b1;
               end
            end else if (int_run && !int_level) begin
               next_st.sw = SCCS_SW_INT;
               irq_ev[IRQ_SWITCH] = 1'b1;
            end
         end
         SCCS_SW_EXT: begin
            next_st.sys_clk = st.ext_level;
            if (!st.clk_sel && int_run && !st.ext_level) begin
               next_st.sw = SCCS_SW_XFER;
            end
         end
         default: begin
            next_st.sw      = SCCS_SW_INT;
            next_st.sys_clk = 1'b0;
         end
      endcase

      // Sticky status; a new event beats a clear in the same cycle
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_en);
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign apb_rsp      = st.rsp;
   assign system_clock = st.sys_clk;
   assign ext_drive_on = st.ext_drive_on;
   assign irq          = st.irq;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_INT_RB_ZERO: assert property (
      done && !apb_req.pwrite && aligned && idx == INT_CTRL_IDX
      |-> st.rsp.prdata[31:5] == 27'h0 && st.rsp.prdata[CLK_SEL_BIT] == st.clk_sel)
      else $error("internal control readback wrong");
   AST_EXT_RB_ZERO: assert property (
      done && !apb_req.pwrite && aligned && idx == EXT_CTRL_IDX
      |-> !st.rsp.prdata[7] && !st.rsp.prdata[3] && st.rsp.prdata[6:4] == st.ext_mode)
      else $error("external control readback wrong");
   AST_EXT_OFF: assert property (
      st.ext_mode[2:1] == 2'b00 |-> !st.ext_drive_on ##1 !st.ext_level)
      else $error("external drive on in off mode");
   AST_PIN_TAKEN: assert property (
      st.ext_mode inside {3'h2, 3'h3, 3'h4, 3'h5} |-> st.ext_drive_on)
      else $error("clock pin not taken in active mode");
   AST_CMOS_DIRECT: assert property (
      st.ext_drive_on && st.ext_mode == SCCS_XM_CMOS |=> st.ext_level == $past(ext_clock_pin))
      else $error("CMOS mode does not follow the pin");
   // Skip the cycle right after leaving direct mode; level still follows the pin there
   AST_HALVED: assert property (
      st.ext_drive_on && st.ext_mode != SCCS_XM_CMOS && $past(st.ext_mode) != SCCS_XM_CMOS &&
      ext_clock_pin && !st.pin_q
      |=> st.ext_level != $past(st.ext_level))
      else $error("divide-by-2 stage missed an edge");
   AST_RESET_SRC: assert property (
      $rose(presetn) |-> st.sw == SCCS_SW_INT && st.int_div == 2'b00 && !st.clk_sel)
      else $error("reset did not select internal divide by 8");
   AST_SWITCH_LIVE: assert property (
      st.sw == SCCS_SW_XFER ##1 st.sw == SCCS_SW_EXT |-> $past(st.ext_run))
      else $error("switched to a stopped external source");
   AST_SWITCH_LOW: assert property (
      $changed(st.sw) |-> !st.sys_clk ##1 (st.sw != SCCS_SW_XFER || !st.sys_clk))
      else $error("system clock high across a source switch");
   AST_RDY_DELAY: assert property (
      $rose(st.int_en) |-> (!st.int_rdy)[*8] ##3 (st.int_rdy || !st.int_en))
      else $error("ready flag timing wrong");
   // Leaves the external source at its first low cycle once deselected while the internal source runs
   AST_SEL_FOLLOW: assert property (
      st.sw == SCCS_SW_EXT && !st.clk_sel && int_run && !st.ext_level
      |=> st.sw == SCCS_SW_XFER)
      else $error("external source kept against select");

   // Register writes land on the completing edge
   AST_DIV_WRITE: assert property (
      done && apb_req.pwrite && aligned && idx == INT_CTRL_IDX
      |=> st.int_div == $past(apb_req.pwdata[INT_DIV_LSB +: 2]))
      else $error("divider field write lost");
   AST_SEL_WRITE: assert property (
      done && apb_req.pwrite && aligned && idx == INT_CTRL_IDX
      |=> st.clk_sel == $past(apb_req.pwdata[CLK_SEL_BIT]))
      else $error("source select write lost");
   AST_EN_WRITE: assert property (
      done && apb_req.pwrite && aligned && idx == INT_CTRL_IDX
      |=> st.int_en == $past(apb_req.pwdata[INT_EN_BIT]))
      else $error("oscillator enable write lost");
   AST_MODE_WRITE: assert property (
      done && apb_req.pwrite && aligned && idx == EXT_CTRL_IDX
      |=> st.ext_mode == $past(apb_req.pwdata[EXT_MODE_LSB +: 3]))
      else $error("external mode write lost");
   AST_RDY_DROP: assert property (
      !st.int_en
      |=> !st.int_rdy)
      else $error("ready flag kept with oscillator off");
   AST_RSV_OFF: assert property (
      st.ext_mode[2:1] == 2'b11
      |-> !st.ext_drive_on)
      else $error("reserved mode drives the pin");

   // Clock path: INT and EXT pass only their own source, XFER holds the clock low
   AST_SYS_INT: assert property (
      st.sw == SCCS_SW_INT
      |=> st.sys_clk == $past(int_level))
      else $error("system clock not from internal source");
   AST_SYS_EXT: assert property (
      st.sw == SCCS_SW_EXT
      |=> st.sys_clk == $past(st.ext_level))
      else $error("system clock not from external source");
   AST_XFER_LOW: assert property (
      st.sw == SCCS_SW_XFER
      |=> !st.sys_clk)
      else $error("system clock high during hand-over");
   AST_HOLD_STOPPED: assert property (
      st.sw == SCCS_SW_INT && !st.ext_run
      |=> st.sw == SCCS_SW_INT)
      else $error("left internal source for a stopped one");

   COV_TO_EXT:  cover property (st.sw == SCCS_SW_XFER ##1 st.sw == SCCS_SW_EXT);
   COV_TO_INT:  cover property (st.sw == SCCS_SW_XFER ##1 st.sw == SCCS_SW_INT);
   COV_RDY:     cover property ($rose(st.int_rdy));
   COV_IRQ:     cover property ($rose(irq));
   COV_LOST:    cover property ($rose(st.irq_stat[IRQ_EXT_LOST]));

endmodule

//--- rtl/sccs_int_divider.sv
`timescale 1ns/1ps

module sccs_int_divider (
   input  wire logic       pclk,     // Bus clock, stands in for the oscillator
   input  wire logic       presetn,  // Async reset, active low
   input  wire logic       run,      // Oscillator enabled and ready
   input  wire logic [1:0] div_code, // Divide select
   output logic            level     // Scaled internal clock
);
   import sccs_pkg::*;

   sccs_div_state_t st;
   sccs_div_state_t next_st;

   // Half-period counter; new code loads only at a toggle
   always_comb begin
      next_st = st;
      if (st.cnt != 3'h0) begin
         next_st.cnt = st.cnt - 3'h1;
      end else if (run || st.level) begin
         next_st.level = ~st.level;
         case (div_code)
            2'b00:   next_st.cnt = RLD_DIV8;
            2'b01:   next_st.cnt = RLD_DIV4;
            2'b10:   next_st.cnt = RLD_DIV2;
            default: next_st.cnt = RLD_DIV1;
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= DIV_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Reload was taken from the code one cycle before the rise
   AST_DIV8_HIGH: assert property (
      $rose(level) && $past(div_code) == 2'b00 |=> (!$changed(level))[*7] ##1 $fell(level))
      else $error("divide by 8 high phase not eight cycles");
   AST_DIV1_HIGH: assert property (
      $rose(level) && $past(div_code) == 2'b11 |=> $fell(level))
      else $error("undivided high phase not one cycle");

endmodule

//--- rtl/sccs_pkg.sv
package sccs_pkg;

   // Bus clock period
   localparam int CLK_PERIOD_NS = 100;

   // Register indices; byte address is four times the index
   localparam logic [7:0] EXT_CTRL_IDX   = 8'hB1;
   localparam logic [7:0] INT_CTRL_IDX   = 8'hB2;
   localparam logic [7:0] IRQ_STATUS_IDX = 8'hB4;
   localparam logic [7:0] IRQ_CLEAR_IDX  = 8'hB5;
   localparam logic [7:0] IRQ_ENABLE_IDX = 8'hB6;
   localparam int         ADDR_W         = 12;

   // Internal oscillator control fields
   localparam int INT_DIV_LSB = 0;
   localparam int INT_EN_BIT  = 2;
   localparam int CLK_SEL_BIT = 3;
   localparam int INT_RDY_BIT = 4;

   // External oscillator control fields
   localparam int EXT_FREQ_LSB = 0;
   localparam int EXT_MODE_LSB = 4;

   // Values after reset
   localparam logic [1:0] INT_DIV_RST  = 2'h0;
   localparam logic       INT_EN_RST   = 1'b1;
   localparam logic       CLK_SEL_RST  = 1'b0;
   localparam logic       INT_RDY_RST  = 1'b1;
   localparam logic [2:0] EXT_MODE_RST = 3'h0;
   localparam logic [2:0] EXT_FREQ_RST = 3'h0;

   // Half-period reload per divide code (count minus one)
   localparam logic [2:0] RLD_DIV8 = 3'h7;
   localparam logic [2:0] RLD_DIV4 = 3'h3;
   localparam logic [2:0] RLD_DIV2 = 3'h1;
   localparam logic [2:0] RLD_DIV1 = 3'h0;

   // Oscillator start-up (least time, rounded up)
   localparam int INT_STARTUP_NS  = 1000;
   localparam int INT_STARTUP_CYC = (INT_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RDY_CNT_W       = 4;
   // Silence on the external pin before it counts as stopped (longest, rounded down)
   localparam int EXT_LOST_NS     = 12000;
   localparam int EXT_LOST_CYC    = EXT_LOST_NS / CLK_PERIOD_NS;
   localparam int EXT_CNT_W       = 7;

   // Interrupt status bits
   localparam int IRQ_INT_RDY  = 0;
   localparam int IRQ_SWITCH   = 1;
   localparam int IRQ_EXT_LOST = 2;
   localparam int IRQ_W        = 3;

   typedef enum logic [2:0] {
      SCCS_XM_OFF0      = 3'h0,
      SCCS_XM_OFF1      = 3'h1,
      SCCS_XM_CMOS      = 3'h2,
      SCCS_XM_CMOS_DIV2 = 3'h3,
      SCCS_XM_RC_DIV2   = 3'h4,
      SCCS_XM_CAP_DIV2  = 3'h5,
      SCCS_XM_RSV6      = 3'h6,
      SCCS_XM_RSV7      = 3'h7
   } sccs_xmode_t;

   typedef enum logic [2:0] {
      SCCS_SW_INT  = 3'b001,
      SCCS_SW_XFER = 3'b010,
      SCCS_SW_EXT  = 3'b100
   } sccs_sw_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } sccs_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } sccs_apb_rsp_t;

   typedef struct packed {
      logic [2:0] cnt;
      logic       level;
   } sccs_div_state_t;

   typedef struct packed {
      sccs_apb_rsp_t        rsp;
      logic [1:0]           int_div;
      logic                 int_en;
      logic                 clk_sel;
      logic                 int_rdy;
      logic [RDY_CNT_W-1:0] rdy_cnt;
      logic [2:0]           ext_mode;
      logic [2:0]           ext_freq;
      logic                 pin_q;
      logic                 ext_div;
      logic                 ext_level;
      logic [EXT_CNT_W-1:0] ext_cnt;
      logic                 ext_run;
      logic                 ext_drive_on;
      sccs_sw_t             sw;
      logic                 sys_clk;
      logic [IRQ_W-1:0]     irq_stat;
      logic [IRQ_W-1:0]     irq_en;
      logic                 irq;
   } sccs_state_t;

   localparam sccs_div_state_t DIV_STATE_RST = '{cnt: 3'h0, level: 1'b0};

   localparam sccs_state_t STATE_RST = '{
      int_div: INT_DIV_RST, int_en: INT_EN_RST, clk_sel: CLK_SEL_RST,
      int_rdy: INT_RDY_RST, ext_mode: EXT_MODE_RST, ext_freq: EXT_FREQ_RST,
      sw: SCCS_SW_INT, default: '0};

endpackage

//--- verification/sccs_ext_clk_model.sv
`timescale 1ns/1ps

// External CMOS clock source on the shared pin
module sccs_ext_clk_model (
   input  wire logic       pclk,    // Bench clock
   input  wire logic       presetn, // Reset, active low
   input  wire logic       run,     // Source running
   input  wire logic [3:0] half,    // Half period in pclk cycles
   output logic            pin      // Clock level on the pin
);
   logic [3:0] cnt;

   // digital CMOS drive
   // A stopped clock holds its level, as a real oscillator would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin <= 1'b0;
         cnt <= 4'h0;
      end else if (!run) begin
         cnt <= 4'h0;
      end else if (cnt == half - 4'h1) begin
         cnt <= 4'h0;
         pin <= ~pin;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

//--- verification/system_clock_source_select_tb_top.sv
`timescale 1ns/1ps

module system_clock_source_select_tb_top;
   import sccs_pkg::*;
   localparam logic [11:0] A_EXT = {2'h0, EXT_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_INT = {2'h0, INT_CTRL_IDX, 2'h0};
   localparam logic [11:0] A_STA = {2'h0, IRQ_STATUS_IDX, 2'h0};
   localparam logic [11:0] A_CLR = {2'h0, IRQ_CLEAR_IDX, 2'h0};
   localparam logic [11:0] A_IEN = {2'h0, IRQ_ENABLE_IDX, 2'h0};
   localparam logic [11:0] A_UNM = 12'h2CC;
   logic          pclk;
   logic          presetn;
   sccs_apb_req_t req;
   sccs_apb_rsp_t rsp;
   logic          pin;
   logic          sys_clk;
   logic          drive_on;
   logic          irq;
   logic          run;
   logic [3:0]    half;
   int            n_mismatch;
   int            tests_run;

   sccs_clock_select u_dut (
      .pclk          (pclk),
      .presetn       (presetn),
      .apb_req       (req),
      .apb_rsp       (rsp),
      .ext_clock_pin (pin),
      .system_clock  (sys_clk),
      .ext_drive_on  (drive_on),
      .irq           (irq)
   );

   // pin kept for the clock, nothing else drives it
   sccs_ext_clk_model u_ext (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (run),
      .half    (half),
      .pin     (pin)
   );

   // 10 MHz bench clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic timeout(input string name);
      n_mismatch++;
      $display("Error %s expected done seen timeout", name);
      report_and_stop();
   endtask

   // One APB transfer; idle edge first so no signal is set twice in a step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int i;
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (rsp.pready === 1'b1) break;
      end
      if (i == 20) timeout("pready");
      q = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string name);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      check(name, q, exp);
   endtask

   task automatic poll(input logic [11:0] a, input logic [31:0] m, input string name);
      int          i;
      logic [31:0] q;
      logic        e;
      for (i = 0; i < 80; i++) begin
         apb(1'b0, a, 32'h0, q, e);
         if ((q & m) === m) break;
      end
      if (i == 80) timeout(name);
   endtask

   // High time of the system clock, in pclk cycles
   task automatic meas(output logic [31:0] n);
      int i;
      n = 0;
      for (i = 0; i < 200 && sys_clk !== 1'b0; i++) @(posedge pclk);
      for (i = 0; i < 200 && sys_clk !== 1'b1; i++) @(posedge pclk);
      if (i == 200) timeout("system_clock");
      while (sys_clk === 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
   endtask

   task automatic t_reset();
      logic [31:0] n;
      rdc(A_INT, 32'h14, "int_ctrl_rst");
      rdc(A_EXT, 32'h0, "ext_ctrl_rst");
      meas(n);
      meas(n);
      check("div8_half", n, 32'h8);
      check("drive_rst", drive_on, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_div();
      logic [31:0] n;
      for (int c = 0; c < 4; c++) begin
         wr(A_INT, 32'h4 | c);
         meas(n);
         meas(n);
         check("div_half", n, 32'h8 >> c);
      end
      $display("test divider done");
   endtask

   // Read-only and unused bits, unmapped place
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      wr(A_INT, 32'hFFFF_FFE7);
      rdc(A_INT, 32'h17, "int_ctrl_mask");
      wr(A_EXT, 32'hFFFF_FFFF);
      rdc(A_EXT, 32'h77, "ext_ctrl_mask");
      apb(1'b0, A_UNM, 32'h0, q, e);
      check("unmapped_err", e, 32'h1);
      check("unmapped_data", q, 32'h0);
      $display("test registers done");
   endtask

   task automatic t_modes();
      for (int m = 0; m < 8; m++) begin
         wr(A_EXT, m << 4);
         repeat (2) @(posedge pclk);
         check("drive_on", drive_on, (m >= 2 && m <= 5));
      end
      $display("test modes done");
   endtask

   // Ready start-up, interrupt raise, mask and clear
   task automatic t_ready();
      wr(A_CLR, 32'h7);
      wr(A_IEN, 32'h1);
      wr(A_INT, 32'h3);
      rdc(A_INT, 32'h3, "rdy_off");
      wr(A_INT, 32'h7);
      rdc(A_INT, 32'h7, "rdy_startup");
      repeat (12) @(posedge pclk);
      rdc(A_INT, 32'h17, "rdy_on");
      check("irq_rdy", irq, 32'h1);
      wr(A_IEN, 32'h0);
      repeat (2) @(posedge pclk);
      check("irq_mask", irq, 32'h0);
      wr(A_IEN, 32'h1);
      wr(A_CLR, 32'h1);
      repeat (2) @(posedge pclk);
      check("irq_clr", irq, 32'h0);
      $display("test ready done");
   endtask

   task automatic t_switch();
      logic [31:0] n;
      logic [31:0] q;
      logic        e;
      wr(A_CLR, 32'h7);
      wr(A_IEN, 32'h2);
      wr(A_EXT, 32'h20);
      wr(A_INT, 32'hF);
      repeat (40) @(posedge pclk);
      apb(1'b0, A_STA, 32'h0, q, e);
      check("switch_held", q[1], 32'h0);
      run <= 1'b1;
      poll(A_STA, 32'h2, "switch_ext");
      check("irq_switch", irq, 32'h1);
      meas(n);
      meas(n);
      check("cmos_half", n, 32'h3);
      for (int m = 3; m < 6; m++) begin
         wr(A_EXT, (m << 4) | m);
         rdc(A_EXT, (m << 4) | m, "ext_freq_rb");
         meas(n);
         meas(n);
         check("div2_half", n, 32'h6);
      end
      wr(A_CLR, 32'h2);
      wr(A_INT, 32'h7);
      poll(A_STA, 32'h2, "switch_int");
      meas(n);
      meas(n);
      check("back_half", n, 32'h1);
      wr(A_CLR, 32'h7);
      wr(A_IEN, 32'h4);
      run <= 1'b0;
      repeat (100) @(posedge pclk);
      apb(1'b0, A_STA, 32'h0, q, e);
      check("lost_early", q[2], 32'h0);
      poll(A_STA, 32'h4, "lost");
      check("irq_lost", irq, 32'h1);
      $display("test switch done");
   endtask

   // Main sequence
   initial begin
      req        = '0;
      presetn    = 1'b0;
      run        = 1'b0;
      half       = 4'h3;
      n_mismatch = 0;
      tests_run  = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_div();
      t_regs();
      t_modes();
      t_ready();
      t_switch();
      report_and_stop();
   end
endmodule
